/* dv/scu_card_model.sv */
// open-drain card io model with pull-up for both slots
`timescale 1ns/1ps
module scu_card_model (
  // pin drive from the block
  input wire logic [1:0] io_out_i,
  input wire logic [1:0] io_oe_i,
  // card side pulls the line low
  input wire logic [1:0] card_low_i,
  // resolved line level
  output logic [1:0] io_line_o
);
  // pull-up wins unless a party pulls low, so a released line never shows stale data
  assign io_line_o = ~((io_oe_i & ~io_out_i) | card_low_i);
endmodule : scu_card_model

/* dv/scu_slot_config_tb.sv */
// self-checking bench of the slot configuration block
`timescale 1ns/1ps
`include "scu_params.svh"
module scu_slot_config_tb;
  import scu_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  scu_addr_t addr_i = 8'h00;
  scu_word_t wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  scu_slot_vec_t aux_f = 2'h0;
  scu_slot_vec_t par_f = 2'h0;
  scu_slot_vec_t lvl_f = 2'h0;
  logic prem_f = 1'b0;
  logic noans_f = 1'b0;
  logic fifo_acc_i = 1'b0;
  logic fifo_acc_word_i = 1'b0;
  logic atr_reset_i = 1'b0;
  scu_slot_vec_t tx_bit0_i = 2'h3;
  scu_slot_vec_t card_low = 2'h0;
  scu_slot_vec_t uart_oe = 2'h0;
  scu_slot_vec_t io_line;
  scu_word_t rdata_o;
  scu_slot_vec_t irq_req_o, word_access_o, fifo_flush_o, parity_check_en_o, gt_sw;
  scu_slot_vec_t card_clk_tick_o, io_out_o, io_oe_o, io_rx_o, sync_mode_o;
  logic word_access_err_o, card_clock_o, aux_card_clock_o, card_reset_o;
  int err_total = 0;
  int check_count = 0;
  int divs [8] = '{1, 2, 3, 4, 5, 6, 8, 16};

  always #20 clk_i = ~clk_i;

  scu_slot_config u_scu_slot_config (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .aux_contact_flag_i(aux_f),
    .parity_error_flag_i(par_f), .fifo_level_flag_i(lvl_f), .premature_flag_i(prem_f),
    .no_answer_flag_i(noans_f), .irq_req_o(irq_req_o), .fifo_acc_i(fifo_acc_i),
    .fifo_acc_word_i(fifo_acc_word_i), .word_access_o(word_access_o),
    .word_access_err_o(word_access_err_o), .fifo_flush_o(fifo_flush_o),
    .parity_check_en_o(parity_check_en_o), .guard_time_by_software_o(gt_sw),
    .card_clock_o(card_clock_o), .aux_card_clock_o(aux_card_clock_o),
    .card_clk_tick_o(card_clk_tick_o), .atr_reset_i(atr_reset_i),
    .card_reset_o(card_reset_o), .uart_io_out_i(2'h0), .uart_io_oe_i(uart_oe),
    .tx_bit0_i(tx_bit0_i), .io_in_i(io_line), .io_out_o(io_out_o), .io_oe_o(io_oe_o),
    .io_rx_o(io_rx_o), .sync_mode_o(sync_mode_o)
  );

  scu_card_model u_scu_card_model (
    .io_out_i(io_out_o), .io_oe_i(io_oe_o), .card_low_i(card_low), .io_line_o(io_line)
  );

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  task automatic wr(input scu_addr_t a, input scu_word_t d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd_chk(input scu_addr_t a, input scu_word_t e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask : rd_chk

  // 240 is a multiple of every divisor, so the tick count is exact
  task automatic ticks(input int s, input int e);
    int n;
    n = 0;
    repeat (240) begin
      @(posedge clk_i);
      #1;
      if (card_clk_tick_o[s] === 1'b1) n++;
    end
    chk(32'(n), 32'(e));
  endtask : ticks

  task automatic set_flag(input int k, input logic v);
    @(posedge clk_i);
    case (k)
      5: aux_f[0] <= v;
      4: prem_f <= v;
      3: par_f[0] <= v;
      default: lvl_f[0] <= v;
    endcase
  endtask : set_flag

  task automatic t_banks;
    rd_chk(`SCU_OFS_UART_CONFIG_TWO, `SCU_REG_RESET);
    rd_chk(`SCU_OFS_CARD_CLOCK_CONFIG, `SCU_REG_RESET);
    wr(`SCU_OFS_UART_CONFIG_TWO, 32'hFFFF_FFBF);
    wr(`SCU_OFS_SLOT_SELECT, 32'h0000_0001);
    rd_chk(`SCU_OFS_UART_CONFIG_TWO, 32'h0000_0000);
    wr(`SCU_OFS_UART_CONFIG_TWO, 32'hFFFF_FFBF);
    wr(`SCU_OFS_CARD_CLOCK_CONFIG, 32'hFFFF_FFFF);
    rd_chk(`SCU_OFS_UART_CONFIG_TWO, 32'h0000_00AE);
    rd_chk(`SCU_OFS_CARD_CLOCK_CONFIG, 32'h0000_002F);
    wr(`SCU_OFS_SLOT_SELECT, 32'h0000_0000);
    rd_chk(`SCU_OFS_UART_CONFIG_TWO, 32'h0000_00BE);
    rd_chk(`SCU_OFS_CARD_CLOCK_CONFIG, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    chk(32'(gt_sw), 32'h3);
    chk(32'(parity_check_en_o), 32'h0);
    chk(32'(word_access_o), 32'h3);
    wr(`SCU_OFS_UART_CONFIG_TWO, 32'h0000_0000);
    wr(`SCU_OFS_SLOT_SELECT, 32'h0000_0001);
    wr(`SCU_OFS_UART_CONFIG_TWO, 32'h0000_0000);
    wr(`SCU_OFS_CARD_CLOCK_CONFIG, 32'h0000_0000);
    wr(`SCU_OFS_SLOT_SELECT, 32'h0000_0000);
    cyc(1);
    chk(32'(parity_check_en_o), 32'h3);
    chk(32'(gt_sw), 32'h0);
  endtask : t_banks

  task automatic t_irq;
    for (int k = 2; k < 6; k++) begin
      set_flag(k, 1'b1);
      cyc(2);
      chk(32'(irq_req_o), 32'h1);
      wr(`SCU_OFS_UART_CONFIG_TWO, 32'h1 << k);
      cyc(2);
      chk(32'(irq_req_o), 32'h0);
      set_flag(k, 1'b0);
      wr(`SCU_OFS_UART_CONFIG_TWO, 32'h0000_0000);
    end
    @(posedge clk_i);
    noans_f <= 1'b1;
    aux_f[1] <= 1'b1;
    cyc(2);
    chk(32'(irq_req_o), 32'h3);
    wr(`SCU_OFS_UART_CONFIG_TWO, 32'h0000_0010);
    wr(`SCU_OFS_SLOT_SELECT, 32'h0000_0001);
    wr(`SCU_OFS_UART_CONFIG_TWO, 32'h0000_0020);
    cyc(2);
    chk(32'(irq_req_o), 32'h0);
    wr(`SCU_OFS_UART_CONFIG_TWO, 32'h0000_0000);
    wr(`SCU_OFS_SLOT_SELECT, 32'h0000_0000);
    wr(`SCU_OFS_UART_CONFIG_TWO, 32'h0000_0000);
  endtask : t_irq

  task automatic t_fifo;
    wr(`SCU_OFS_UART_CONFIG_TWO, 32'h0000_0080);
    @(posedge clk_i);
    fifo_acc_i <= 1'b1;
    @(posedge clk_i);
    fifo_acc_i <= 1'b0;
    #1;
    chk(32'(word_access_err_o), 32'h1);
    @(posedge clk_i);
    fifo_acc_word_i <= 1'b1;
    fifo_acc_i <= 1'b1;
    @(posedge clk_i);
    fifo_acc_i <= 1'b0;
    #1;
    chk(32'(word_access_err_o), 32'h0);
    // flush bit is set by the write and clears the next cycle
    wr(`SCU_OFS_UART_CONFIG_TWO, 32'h0000_0040);
    #1;
    chk(32'(fifo_flush_o), 32'h1);
    cyc(1);
    chk(32'(fifo_flush_o), 32'h0);
    rd_chk(`SCU_OFS_UART_CONFIG_TWO, 32'h0000_0000);
  endtask : t_fifo

  task automatic t_clock;
    for (int c = 0; c < 8; c++) begin
      wr(`SCU_OFS_CARD_CLOCK_CONFIG, 32'(c));
      cyc(40);
      ticks(0, 240 / divs[c]);
    end
    wr(`SCU_OFS_CARD_CLOCK_CONFIG, 32'h0000_0031);
    cyc(40);
    chk(32'(card_clock_o), 32'h1);
    ticks(0, 0);
    wr(`SCU_OFS_CARD_CLOCK_CONFIG, 32'h0000_0011);
    cyc(40);
    chk(32'(card_clock_o), 32'h0);
    // slot1 sync mode with stop level high: clock pin copies the stop level
    wr(`SCU_OFS_CARD_CLOCK_CONFIG, 32'h0000_0028);
    cyc(2);
    chk(32'(card_clock_o), 32'h1);
    chk(32'(sync_mode_o), 32'h1);
  endtask : t_clock

  task automatic t_sync;
    @(posedge clk_i);
    tx_bit0_i[0] <= 1'b0;
    cyc(2);
    chk(32'({io_oe_o[0], io_out_o[0]}), 32'h2);
    cyc(5);
    chk(32'(io_rx_o[0]), 32'h0);
    wr(`SCU_OFS_CARD_RESET, 32'h0000_0001);
    cyc(2);
    chk(32'(card_reset_o), 32'h1);
    wr(`SCU_OFS_CARD_RESET, 32'h0000_0000);
    // uart drive must stay bypassed while the slot is in sync mode
    tx_bit0_i[0] <= 1'b1;
    uart_oe <= 2'h1;
    cyc(2);
    chk(32'({io_oe_o[0], card_reset_o}), 32'h0);
    wr(`SCU_OFS_CARD_CLOCK_CONFIG, 32'h0000_0000);
    atr_reset_i <= 1'b1;
    card_low[0] <= 1'b1;
    cyc(6);
    chk(32'({card_reset_o, io_rx_o[0], io_oe_o[0]}), 32'h5);
    @(posedge clk_i);
    atr_reset_i <= 1'b0;
    card_low[0] <= 1'b0;
    uart_oe <= 2'h0;
  endtask : t_sync

  task automatic t_aux;
    wr(`SCU_OFS_SLOT_SELECT, 32'h0000_0001);
    // stop level and mode chosen while the aux clock is off
    wr(`SCU_OFS_CARD_CLOCK_CONFIG, 32'h0000_0023);
    cyc(2);
    chk(32'(aux_card_clock_o), 32'h1);
    ticks(1, 0);
    wr(`SCU_OFS_SLOT_SELECT, 32'h0000_0003);
    cyc(40);
    ticks(1, 60);
    wr(`SCU_OFS_SLOT_SELECT, 32'h0000_0001);
    cyc(40);
    chk(32'(aux_card_clock_o), 32'h1);
    wr(`SCU_OFS_CARD_CLOCK_CONFIG, 32'h0000_0008);
    cyc(2);
    chk(32'({sync_mode_o, aux_card_clock_o}), 32'h4);
  endtask : t_aux

  initial begin
    #800000;
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_banks();
    t_irq();
    t_fifo();
    t_clock();
    t_sync();
    t_aux();
    wrap_up();
  end
endmodule : scu_slot_config_tb

/* shared/scu_params.svh */
// register map, field positions and reset values of the slot configuration block
`ifndef SCU_PARAMS_SVH
`define SCU_PARAMS_SVH
`define SCU_OFS_UART_CONFIG_TWO 8'h18
`define SCU_OFS_CARD_CLOCK_CONFIG 8'h1C
`define SCU_OFS_SLOT_SELECT 8'h30
`define SCU_OFS_CARD_RESET 8'h34
`define SCU_OFS_CLOCK_STATUS 8'h38
`define SCU_UC_WORD_ACCESS 7
`define SCU_UC_FIFO_FLUSH 6
`define SCU_UC_AUX_IRQ_MASK 5
`define SCU_UC_ANSWER_IRQ_MASK 4
`define SCU_UC_PARITY_OFF 3
`define SCU_UC_LEVEL_IRQ_MASK 2
`define SCU_UC_GUARD_BY_SW 1
`define SCU_CC_STOP_LEVEL 5
`define SCU_CC_HALT 4
`define SCU_CC_SYNC 3
`define SCU_CC_DIV_HI 2
`define SCU_CC_DIV_LO 0
`define SCU_SS_AUX_SELECT 0
`define SCU_SS_AUX_CLK_EN 1
`define SCU_RST_LEVEL 0
`define SCU_UC_MASK_MAIN 32'h0000_00FE
`define SCU_UC_MASK_AUX 32'h0000_00EE
`define SCU_CC_MASK_MAIN 32'h0000_003F
`define SCU_CC_MASK_AUX 32'h0000_002F
`define SCU_SS_MASK 32'h0000_0003
`define SCU_RST_MASK 32'h0000_0001
`define SCU_REG_RESET 32'h0000_0000
`endif

/* shared/scu_pkg.sv */
// types shared by the slot configuration block
package scu_pkg;
  typedef logic [7:0] scu_addr_t;
  typedef logic [31:0] scu_word_t;
  typedef logic [2:0] scu_div_code_t;
  typedef logic [4:0] scu_div_t;
  typedef logic [1:0] scu_slot_vec_t;
endpackage : scu_pkg

/* src/scu_slot_config.sv */
// banked uart and card clock configuration for the main and auxiliary card slots
//
// Operation
// - two uart config copies, one address, slot-selected
// - two clock config copies, one address, slot-selected
// - word access bit sets fifo access width
// - flush bit empties fifo, self-clears next cycle
// - aux mask bit blocks aux contact interrupt
// - slot1 answer mask blocks premature, no-answer interrupts
// - aux uart copy lacks answer mask bit
// - parity off: no check, no parity interrupt
// - level mask blocks fifo threshold interrupt
// - guard time by software or hardware
// - slot1 halted clock rests at stop level
// - sync mode: clock pin copies stop level
// - aux disabled clock rests at stop level
// - slot1 halt stops clock, else divided clock
// - aux clock copy lacks halt bit
// - sync mode bypasses uart, bit0 on io
// - divider codes 0..7 divide by 1..16, glitch-free changes
// - sync reset from level bit, else answer logic
`timescale 1ns/1ps
`include "scu_params.svh"
module scu_slot_config (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire scu_pkg::scu_addr_t addr_i,
  input wire scu_pkg::scu_word_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output scu_pkg::scu_word_t rdata_o,
  // status flags from the uart, per slot (index 1 is aux); premature and no-answer are main slot only
  input wire scu_pkg::scu_slot_vec_t aux_contact_flag_i,
  input wire scu_pkg::scu_slot_vec_t parity_error_flag_i,
  input wire scu_pkg::scu_slot_vec_t fifo_level_flag_i,
  input wire logic premature_flag_i,
  input wire logic no_answer_flag_i,
  output scu_pkg::scu_slot_vec_t irq_req_o,
  // fifo control
  input wire logic fifo_acc_i,
  input wire logic fifo_acc_word_i,
  output scu_pkg::scu_slot_vec_t word_access_o,
  output logic word_access_err_o,
  output scu_pkg::scu_slot_vec_t fifo_flush_o,
  output scu_pkg::scu_slot_vec_t parity_check_en_o,
  output scu_pkg::scu_slot_vec_t guard_time_by_software_o,
  // card clocks
  output logic card_clock_o,
  output logic aux_card_clock_o,
  output scu_pkg::scu_slot_vec_t card_clk_tick_o,
  // card reset
  input wire logic atr_reset_i,
  output logic card_reset_o,
  // card io, open drain per slot
  input wire scu_pkg::scu_slot_vec_t uart_io_out_i,
  input wire scu_pkg::scu_slot_vec_t uart_io_oe_i,
  input wire scu_pkg::scu_slot_vec_t tx_bit0_i,
  input wire scu_pkg::scu_slot_vec_t io_in_i,
  output scu_pkg::scu_slot_vec_t io_out_o,
  output scu_pkg::scu_slot_vec_t io_oe_o,
  output scu_pkg::scu_slot_vec_t io_rx_o,
  output scu_pkg::scu_slot_vec_t sync_mode_o
);
  import scu_pkg::*;

  function automatic scu_div_t div_of(input scu_div_code_t code);
    case (code)
      3'h0: div_of = 5'h01;
      3'h1: div_of = 5'h02;
      3'h2: div_of = 5'h03;
      3'h3: div_of = 5'h04;
      3'h4: div_of = 5'h05;
      3'h5: div_of = 5'h06;
      3'h6: div_of = 5'h08;
      default: div_of = 5'h10;
    endcase
  endfunction : div_of

  // register state
  scu_word_t uc [2], cc [2], next_uc [2], next_cc [2];
  logic aux_slot_select, aux_clock_enable, card_reset_level, sel;
  logic next_aux_slot_select, next_aux_clock_enable, next_card_reset_level;

  assign sel = aux_slot_select;

  always_comb begin
    for (int s = 0; s < 2; s++) begin
      next_uc[s] = uc[s];
      next_cc[s] = cc[s];
      next_uc[s][`SCU_UC_FIFO_FLUSH] = 1'b0;
    end
    next_aux_slot_select = aux_slot_select;
    next_aux_clock_enable = aux_clock_enable;
    next_card_reset_level = card_reset_level;
    if (wr_i) begin
      case (addr_i)
        `SCU_OFS_UART_CONFIG_TWO: begin
          // aux copy drops the answer mask bit
          next_uc[sel] = wdata_i & (sel ? `SCU_UC_MASK_AUX : `SCU_UC_MASK_MAIN);
        end
        `SCU_OFS_CARD_CLOCK_CONFIG: begin
          // aux copy has no halt bit
          next_cc[sel] = wdata_i & (sel ? `SCU_CC_MASK_AUX : `SCU_CC_MASK_MAIN);
        end
        `SCU_OFS_SLOT_SELECT: begin
          next_aux_slot_select = wdata_i[`SCU_SS_AUX_SELECT];
          next_aux_clock_enable = wdata_i[`SCU_SS_AUX_CLK_EN];
        end
        `SCU_OFS_CARD_RESET: begin
          next_card_reset_level = wdata_i[`SCU_RST_LEVEL];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int s = 0; s < 2; s++) begin
        uc[s] <= `SCU_REG_RESET;
        cc[s] <= `SCU_REG_RESET;
      end
      aux_slot_select <= 1'b0;
      aux_clock_enable <= 1'b0;
      card_reset_level <= 1'b0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        uc[s] <= next_uc[s];
        cc[s] <= next_cc[s];
      end
      aux_slot_select <= next_aux_slot_select;
      aux_clock_enable <= next_aux_clock_enable;
      card_reset_level <= next_card_reset_level;
    end
  end

  // card clock generation; the divisor is only taken at a period boundary
  // so a divider change never shortens a half period
  scu_div_t cnt [2], act_div [2], next_cnt [2], next_act_div [2];
  logic run [2], next_phase [2], next_tick [2];
  scu_slot_vec_t tick;

  assign run[0] = !cc[0][`SCU_CC_SYNC] && !cc[0][`SCU_CC_HALT];
  assign run[1] = !cc[1][`SCU_CC_SYNC] && aux_clock_enable;

  always_comb begin
    for (int s = 0; s < 2; s++) begin
      next_cnt[s] = cnt[s];
      next_act_div[s] = act_div[s];
      next_tick[s] = 1'b0;
      if (!run[s]) begin
        next_cnt[s] = 5'h00;
        next_act_div[s] = div_of(cc[s][`SCU_CC_DIV_HI:`SCU_CC_DIV_LO]);
      end else if (cnt[s] >= act_div[s] - 5'h01) begin
        next_cnt[s] = 5'h00;
        next_tick[s] = 1'b1;
        next_act_div[s] = div_of(cc[s][`SCU_CC_DIV_HI:`SCU_CC_DIV_LO]);
      end else begin
        next_cnt[s] = cnt[s] + 5'h01;
      end
      // high for the first half, rounded up; divide by one stays high
      next_phase[s] = run[s] && (next_cnt[s] < ((next_act_div[s] + 5'h01) >> 1));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int s = 0; s < 2; s++) begin
        cnt[s] <= 5'h00;
        act_div[s] <= 5'h01;
        tick[s] <= 1'b0;
      end
    end else begin
      for (int s = 0; s < 2; s++) begin
        cnt[s] <= next_cnt[s];
        act_div[s] <= next_act_div[s];
        tick[s] <= next_tick[s];
      end
    end
  end

  // io pin synchroniser: three stages, a change counts when the last two agree
  scu_slot_vec_t io_s1;
  scu_slot_vec_t io_s2;
  scu_slot_vec_t io_s3;
  scu_slot_vec_t io_filt;
  scu_slot_vec_t next_io_filt;

  always_comb begin
    next_io_filt = io_filt;
    for (int s = 0; s < 2; s++) begin
      if (io_s2[s] == io_s3[s]) begin
        next_io_filt[s] = io_s3[s];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_s1 <= 2'h3;
      io_s2 <= 2'h3;
      io_s3 <= 2'h3;
      io_filt <= 2'h3;
    end else begin
      io_s1 <= io_in_i;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
      io_filt <= next_io_filt;
    end
  end

  // registered outputs
  scu_word_t next_rdata;
  scu_slot_vec_t next_irq, next_io_out, next_io_oe;
  logic next_card_clock, next_aux_card_clock, next_card_reset, next_word_err;

  always_comb begin
    next_rdata = `SCU_REG_RESET;
    if (rd_i) begin
      case (addr_i)
        `SCU_OFS_UART_CONFIG_TWO: next_rdata = uc[sel];
        `SCU_OFS_CARD_CLOCK_CONFIG: next_rdata = cc[sel];
        `SCU_OFS_SLOT_SELECT: next_rdata = {30'h0, aux_clock_enable, aux_slot_select};
        `SCU_OFS_CARD_RESET: next_rdata = {31'h0, card_reset_level};
        `SCU_OFS_CLOCK_STATUS: begin
          next_rdata = {28'h0, run[1], run[0], aux_card_clock_o, card_clock_o};
        end
        default: next_rdata = `SCU_REG_RESET;
      endcase
    end
    for (int s = 0; s < 2; s++) begin
      next_irq[s] = (aux_contact_flag_i[s] && !uc[s][`SCU_UC_AUX_IRQ_MASK])
        || (parity_error_flag_i[s] && !uc[s][`SCU_UC_PARITY_OFF])
        || (fifo_level_flag_i[s] && !uc[s][`SCU_UC_LEVEL_IRQ_MASK]);
      // bypass in sync mode: io carries bit0, driven low only
      next_io_out[s] = cc[s][`SCU_CC_SYNC] ? 1'b0 : uart_io_out_i[s];
      next_io_oe[s] = cc[s][`SCU_CC_SYNC] ? !tx_bit0_i[s] : uart_io_oe_i[s];
    end
    next_irq[0] = next_irq[0]
      || ((premature_flag_i || no_answer_flag_i) && !uc[0][`SCU_UC_ANSWER_IRQ_MASK]);
    // stopped or sync clock copies the stop level
    next_card_clock = run[0] ? next_phase[0] : cc[0][`SCU_CC_STOP_LEVEL];
    // aux running clock is inverted; stopped it rests at the stop level
    next_aux_card_clock = run[1] ? !next_phase[1] : cc[1][`SCU_CC_STOP_LEVEL];
    next_card_reset = cc[0][`SCU_CC_SYNC] ? card_reset_level : atr_reset_i;
    next_word_err = fifo_acc_i && (fifo_acc_word_i != uc[sel][`SCU_UC_WORD_ACCESS]);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= `SCU_REG_RESET;
      irq_req_o <= 2'h0;
      io_out_o <= 2'h0;
      io_oe_o <= 2'h0;
      card_clock_o <= 1'b0;
      aux_card_clock_o <= 1'b0;
      card_reset_o <= 1'b0;
      word_access_err_o <= 1'b0;
    end else begin
      rdata_o <= next_rdata;
      irq_req_o <= next_irq;
      io_out_o <= next_io_out;
      io_oe_o <= next_io_oe;
      card_clock_o <= next_card_clock;
      aux_card_clock_o <= next_aux_card_clock;
      card_reset_o <= next_card_reset;
      word_access_err_o <= next_word_err;
    end
  end

  // straight register decodes
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      word_access_o[s] = uc[s][`SCU_UC_WORD_ACCESS];
      fifo_flush_o[s] = uc[s][`SCU_UC_FIFO_FLUSH];
      parity_check_en_o[s] = !uc[s][`SCU_UC_PARITY_OFF];
      guard_time_by_software_o[s] = uc[s][`SCU_UC_GUARD_BY_SW];
      sync_mode_o[s] = cc[s][`SCU_CC_SYNC];
      card_clk_tick_o[s] = tick[s];
      io_rx_o[s] = io_filt[s];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  flush_self_clear_a: assert property (
    fifo_flush_o[0] && !(wr_i && addr_i == `SCU_OFS_UART_CONFIG_TWO && !sel)
    |=> !fifo_flush_o[0])
    else $error("flush bit stayed set");
  main_write_back_a: assert property (
    wr_i && addr_i == `SCU_OFS_UART_CONFIG_TWO && !sel
    |=> uc[0] == ($past(wdata_i) & `SCU_UC_MASK_MAIN))
    else $error("main uart copy not written");
  aux_no_answer_a: assert property (cc[1][`SCU_CC_HALT] == 1'b0 && !uc[1][4])
    else $error("aux copy holds missing bit");
  aux_irq_mask_a: assert property (
    aux_contact_flag_i[1] && uc[1][`SCU_UC_AUX_IRQ_MASK] && !parity_error_flag_i[1]
    && !fifo_level_flag_i[1] |=> !irq_req_o[1])
    else $error("aux contact irq not masked");
  answer_mask_a: assert property (
    premature_flag_i && !uc[0][`SCU_UC_ANSWER_IRQ_MASK] |=> irq_req_o[0])
    else $error("premature flag lost");
  parity_mask_a: assert property (
    uc[0][`SCU_UC_PARITY_OFF] |-> !parity_check_en_o[0])
    else $error("parity still checked");
  level_mask_a: assert property (
    fifo_level_flag_i[0] && !uc[0][`SCU_UC_LEVEL_IRQ_MASK] |=> irq_req_o[0])
    else $error("fifo level irq lost");
  sync_clock_copy_a: assert property (
    cc[0][`SCU_CC_SYNC] && $stable(cc[0]) |=> card_clock_o == $past(cc[0][5]))
    else $error("sync clock not stop level");
  halt_level_a: assert property (
    !cc[0][`SCU_CC_SYNC] && cc[0][`SCU_CC_HALT] ##1 $stable(cc[0]) [*3]
    |-> card_clock_o == cc[0][`SCU_CC_STOP_LEVEL])
    else $error("halted clock at wrong level");
  aux_stop_level_a: assert property (
    !aux_clock_enable && $stable(cc[1]) |=> aux_card_clock_o == $past(cc[1][5]))
    else $error("aux clock not stopped at level");
  sync_reset_a: assert property (
    cc[0][`SCU_CC_SYNC] |=> card_reset_o == $past(card_reset_level))
    else $error("sync reset not from level bit");
  div_period_a: assert property (
    card_clk_tick_o[0] && run[0] |-> cnt[0] == 5'h00)
    else $error("tick off period boundary");
endmodule : scu_slot_config
